// ### core/isb_pkg.sv
// Shared constants and state types of the two-wire bus controller.
package isb_pkg;

  // Register byte offsets on the APB side.
  localparam logic [7:0] ISB_OFF_CTRL = 8'h00;
  localparam logic [7:0] ISB_OFF_STAT = 8'h04;
  localparam logic [7:0] ISB_OFF_MASK = 8'h08;
  localparam logic [7:0] ISB_OFF_RATE = 8'h0C;
  localparam logic [7:0] ISB_OFF_TXH = 8'h10;
  localparam logic [7:0] ISB_OFF_RXH = 8'h14;
  localparam logic [7:0] ISB_OFF_OWN = 8'h18;

  // Field positions of control_word.
  localparam int ISB_C_ON = 15;
  localparam int ISB_C_TEN = 10;
  localparam int ISB_C_GC = 7;
  localparam int ISB_C_ACKV = 5;
  localparam int ISB_C_ACKR = 4;
  localparam int ISB_C_RCV = 3;
  localparam int ISB_C_STOP = 2;
  localparam int ISB_C_RST = 1;
  localparam int ISB_C_START = 0;

  // Field positions of bus_status.
  localparam int ISB_S_ACK = 15;
  localparam int ISB_S_BCOL = 10;
  localparam int ISB_S_WCOL = 7;
  localparam int ISB_S_STOP = 4;
  localparam int ISB_S_START = 3;
  localparam int ISB_S_READ = 2;
  localparam int ISB_S_RXF = 1;
  localparam int ISB_S_TXF = 0;

  // Reset values and bus timing figures.
  localparam logic [9:0] ISB_MASK_RESET = 10'h000;
  localparam int ISB_RATE_STEP = 2;
  localparam logic [4:0] ISB_TEN_PREFIX = 5'h1E;
  localparam logic [3:0] ISB_TX_BITS = 4'h9;
  localparam logic [3:0] ISB_RX_BITS = 4'h8;
  localparam logic [3:0] ISB_ACK_BITS = 4'h1;

  // Master sequencer states.
  typedef enum logic [3:0] {
    ISB_M_IDLE, ISB_M_S1, ISB_M_S2, ISB_M_S3, ISB_M_P1, ISB_M_P2, ISB_M_P3, ISB_M_BLO, ISB_M_BHI
  } isb_mstate_t;

  // Slave bit phases and byte kinds.
  typedef enum logic [1:0] {ISB_SL_IDLE, ISB_SL_BYTE, ISB_SL_ACKO, ISB_SL_ACKI} isb_sphase_t;
  typedef enum logic [1:0] {ISB_K_ADDR1, ISB_K_ADDR2, ISB_K_RX, ISB_K_TX} isb_skind_t;

endpackage

// ### core/isb_i2c.sv
// Two-wire bus controller with status, address mask, enable and rate generator.
// Functional notes
// - Start or repeated start sets the start-seen flag; stop clears it.
// - Matching slave address sets direction flag: 1 read, 0 write.
// - Received byte sets rx_holding_full; software read of rx_holding_reg clears it.
// - Software write sets tx_holding_full; byte fully shifted out clears it.
// - Ten-bit addressing: set mask bit makes that address bit don't-care.
// - Seven-bit addressing: mask bit n masks incoming address bit n+1.
// - Mask register top six bits read zero; ten mask bits reset zero.
// - module_on enables controller; master and slave then run together.
// - On enable both lines are released and the bus left idle.
// - Master starts only on a start, restart, stop, receive or acknowledge request, or a tx_holding_reg load.
// - Slave watches bus while module_on is set, starts on start plus matching address.
// - Enabled and unclaimed by higher priority, the controller owns the pins.
// - Master event pulse on start, stop, restart, byte, ack or collision.
// - Slave event pulse on address match, ack/nack of transmit, received byte.
// - rate_generator loads from rate_reload, counts to zero, then holds.
// - rate_generator decrements twice per instruction cycle.
// - rate_generator reloads on timing restart, as when clock is seen high.
// - Master clock period is one low interval plus one high interval.
// - Clock rate follows reload plus one cycles plus input filter delay.
// - start_request clears itself once the generated start completes.
//
// Implementation choices: the APB interface to the registers and the address map.
`timescale 1ns/10ps
`default_nettype none
module isb_i2c
  import isb_pkg::*;
#(
  parameter int ADDR_W = 8,
  parameter int RATE_W = 9
) (
  // Clock and reset.
  input wire logic REF_CLK,
  input wire logic RST,
  // APB slave.
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [ADDR_W-1:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  // Clock line, open drain.
  input wire logic SCL_IN,
  output logic SCL_OUT,
  output logic SCL_OE,
  // Data line, open drain.
  input wire logic SDA_IN,
  output logic SDA_OUT,
  output logic SDA_OE,
  // Pin ownership.
  input wire logic PIN_HELD_ELSEWHERE,
  output logic PIN_TAKEOVER,
  // Event pulses.
  output logic MASTER_EVENT_IRQ,
  output logic SLAVE_EVENT_IRQ
);

  typedef struct packed {
    logic module_on;
    logic ten_bit;
    logic gc_enable;
    logic ack_value;
    logic ack_request;
    logic recv_request;
    logic stop_request;
    logic restart_request;
    logic start_request;
    logic ack_status;
    logic bus_collision;
    logic write_collision;
    logic stop_seen;
    logic start_seen;
    logic slave_read;
    logic rx_holding_full;
    logic tx_holding_full;
    logic [9:0] addr_mask_bits;
    logic [9:0] own_addr;
    logic [RATE_W-1:0] rate_reload;
    logic [RATE_W-1:0] rate_generator;
    logic [7:0] tx_holding_reg;
    logic [7:0] rx_holding_reg;
    logic tx_go;
    logic [31:0] prdata;
    logic pslverr;
    logic scl_f;
    logic sda_f;
    logic scl_p;
    logic sda_p;
    isb_mstate_t m_state;
    logic [8:0] m_shift;
    logic [3:0] m_left;
    logic m_rx;
    logic [7:0] m_in;
    logic m_scl_low;
    logic m_sda_low;
    isb_sphase_t s_phase;
    isb_skind_t s_kind;
    logic [3:0] s_cnt;
    logic [7:0] s_shift;
    logic [7:0] s_tx;
    logic ten_matched;
    logic owned;
    logic scl_low;
    logic sda_low;
    logic m_irq;
    logic s_irq;
  } isb_state_t;

  isb_state_t s;
  isb_state_t next_s;

  logic setup_phase;
  logic wr_access;
  logic rd_access;
  logic [31:0] rd_value;
  logic addr_hit;
  logic master_busy;
  logic rate_done;
  logic scl_rise;
  logic scl_fall;
  logic start_det;
  logic stop_det;
  logic [7:0] byte_in;
  logic match7;
  logic match_gc;
  logic match10_hi;
  logic match10_lo;

  // Bus phase decode and event detection on the filtered lines.
  assign setup_phase = PSEL & ~PENABLE;
  assign wr_access = PSEL & PENABLE & PWRITE;
  assign rd_access = PSEL & PENABLE & ~PWRITE;
  assign master_busy = s.m_state != ISB_M_IDLE;
  assign rate_done = s.rate_generator == '0;
  assign scl_rise = s.scl_f & ~s.scl_p;
  assign scl_fall = ~s.scl_f & s.scl_p;
  assign start_det = s.scl_f & s.scl_p & s.sda_p & ~s.sda_f;
  assign stop_det = s.scl_f & s.scl_p & ~s.sda_p & s.sda_f;
  assign byte_in = s.s_shift;

  // Address comparators with per-bit masking.
  assign match7 = ((byte_in[7:1] ^ s.own_addr[6:0]) & ~s.addr_mask_bits[6:0]) == 7'h00;
  assign match_gc = s.gc_enable & (byte_in == 8'h00);
  assign match10_hi = (byte_in[7:3] == ISB_TEN_PREFIX)
    && (((byte_in[2:1] ^ s.own_addr[9:8]) & ~s.addr_mask_bits[9:8]) == 2'h0);
  assign match10_lo = ((byte_in ^ s.own_addr[7:0]) & ~s.addr_mask_bits[7:0]) == 8'h00;

  // Read multiplexer for the register map.
  always_comb begin
    addr_hit = 1'b1;
    rd_value = 32'h0000_0000;
    if (PADDR == ADDR_W'(ISB_OFF_CTRL)) begin
      rd_value[ISB_C_ON] = s.module_on;
      rd_value[ISB_C_TEN] = s.ten_bit;
      rd_value[ISB_C_GC] = s.gc_enable;
      rd_value[ISB_C_ACKV] = s.ack_value;
      rd_value[ISB_C_ACKR] = s.ack_request;
      rd_value[ISB_C_RCV] = s.recv_request;
      rd_value[ISB_C_STOP] = s.stop_request;
      rd_value[ISB_C_RST] = s.restart_request;
      rd_value[ISB_C_START] = s.start_request;
    end else if (PADDR == ADDR_W'(ISB_OFF_STAT)) begin
      rd_value[ISB_S_ACK] = s.ack_status;
      rd_value[ISB_S_BCOL] = s.bus_collision;
      rd_value[ISB_S_WCOL] = s.write_collision;
      rd_value[ISB_S_STOP] = s.stop_seen;
      rd_value[ISB_S_START] = s.start_seen;
      rd_value[ISB_S_READ] = s.slave_read;
      rd_value[ISB_S_RXF] = s.rx_holding_full;
      rd_value[ISB_S_TXF] = s.tx_holding_full;
    end else if (PADDR == ADDR_W'(ISB_OFF_MASK)) begin
      rd_value[9:0] = s.addr_mask_bits;
    end else if (PADDR == ADDR_W'(ISB_OFF_RATE)) begin
      rd_value[RATE_W-1:0] = s.rate_reload;
    end else if (PADDR == ADDR_W'(ISB_OFF_TXH)) begin
      rd_value[7:0] = s.tx_holding_reg;
    end else if (PADDR == ADDR_W'(ISB_OFF_RXH)) begin
      rd_value[7:0] = s.rx_holding_reg;
    end else if (PADDR == ADDR_W'(ISB_OFF_OWN)) begin
      rd_value[9:0] = s.own_addr;
    end else begin
      addr_hit = 1'b0;
    end
  end

  // Next-state logic: bus slave first so hardware sets below win over clears.
  always_comb begin
    next_s = s;
    next_s.m_irq = 1'b0;
    next_s.s_irq = 1'b0;
    next_s.scl_f = SCL_IN;
    next_s.sda_f = SDA_IN;
    next_s.scl_p = s.scl_f;
    next_s.sda_p = s.sda_f;
    if (setup_phase) begin
      next_s.prdata = rd_value;
      next_s.pslverr = ~addr_hit;
    end
    if (wr_access) begin
      if (PADDR == ADDR_W'(ISB_OFF_CTRL)) begin
        next_s.module_on = PWDATA[ISB_C_ON];
        next_s.ten_bit = PWDATA[ISB_C_TEN];
        next_s.gc_enable = PWDATA[ISB_C_GC];
        next_s.ack_value = PWDATA[ISB_C_ACKV];
        // Request bits cannot be queued behind a running master event.
        if (!master_busy && !s.start_request && !s.restart_request) begin
          next_s.ack_request = PWDATA[ISB_C_ACKR];
          next_s.recv_request = PWDATA[ISB_C_RCV];
          next_s.stop_request = PWDATA[ISB_C_STOP];
          next_s.restart_request = PWDATA[ISB_C_RST];
          next_s.start_request = PWDATA[ISB_C_START];
        end
      end else if (PADDR == ADDR_W'(ISB_OFF_STAT)) begin
        next_s.write_collision = s.write_collision & PWDATA[ISB_S_WCOL];
        next_s.bus_collision = s.bus_collision & PWDATA[ISB_S_BCOL];
      end else if (PADDR == ADDR_W'(ISB_OFF_MASK)) begin
        next_s.addr_mask_bits = PWDATA[9:0];
      end else if (PADDR == ADDR_W'(ISB_OFF_RATE)) begin
        next_s.rate_reload = PWDATA[RATE_W-1:0];
      end else if (PADDR == ADDR_W'(ISB_OFF_OWN)) begin
        next_s.own_addr = PWDATA[9:0];
      end else if (PADDR == ADDR_W'(ISB_OFF_TXH)) begin
        if (master_busy || s.start_request || s.restart_request) begin
          next_s.write_collision = 1'b1;
        end else begin
          next_s.tx_holding_reg = PWDATA[7:0];
          next_s.tx_holding_full = 1'b1;
          // A load that is not slave reply data launches a master transmit.
          next_s.tx_go = ~(s.s_phase != ISB_SL_IDLE && s.s_kind == ISB_K_TX);
        end
      end
    end
    if (rd_access && PADDR == ADDR_W'(ISB_OFF_RXH)) begin
      next_s.rx_holding_full = 1'b0;
    end

    // Rate generator: steps by two per cycle and rests at zero.
    next_s.rate_generator = (s.rate_generator > RATE_W'(ISB_RATE_STEP))
      ? s.rate_generator - RATE_W'(ISB_RATE_STEP) : '0;

    // Master sequencer; each state but ISB_M_IDLE is one rate interval.
    case (s.m_state)
      ISB_M_IDLE: begin
        if (s.module_on && s.owned) begin
          if (s.start_request || s.restart_request) begin
            next_s.m_sda_low = 1'b0;
            next_s.m_state = ISB_M_S1;
            next_s.rate_generator = s.rate_reload;
          end else if (s.stop_request) begin
            next_s.m_sda_low = 1'b1;
            next_s.m_state = ISB_M_P1;
            next_s.rate_generator = s.rate_reload;
          end else if (s.tx_go) begin
            next_s.m_shift = {s.tx_holding_reg, 1'b1};
            next_s.m_left = ISB_TX_BITS;
            next_s.m_rx = 1'b0;
            next_s.m_state = ISB_M_BLO;
            next_s.rate_generator = s.rate_reload;
          end else if (s.recv_request) begin
            next_s.m_shift = 9'h1FF;
            next_s.m_left = ISB_RX_BITS;
            next_s.m_rx = 1'b1;
            next_s.m_state = ISB_M_BLO;
            next_s.rate_generator = s.rate_reload;
          end else if (s.ack_request) begin
            next_s.m_shift = {s.ack_value, 8'hFF};
            next_s.m_left = ISB_ACK_BITS;
            next_s.m_rx = 1'b0;
            next_s.m_state = ISB_M_BLO;
            next_s.rate_generator = s.rate_reload;
          end
        end
      end
      ISB_M_S1: begin
        if (rate_done) begin
          next_s.m_scl_low = 1'b0;
          next_s.m_state = ISB_M_S2;
          next_s.rate_generator = s.rate_reload;
        end
      end
      ISB_M_S2: begin
        if (!s.scl_f) begin
          next_s.rate_generator = s.rate_reload;
        end else if (rate_done) begin
          next_s.m_sda_low = 1'b1;
          next_s.m_state = ISB_M_S3;
          next_s.rate_generator = s.rate_reload;
        end
      end
      ISB_M_S3: begin
        if (rate_done) begin
          next_s.m_scl_low = 1'b1;
          next_s.start_request = 1'b0;
          next_s.restart_request = 1'b0;
          next_s.m_irq = 1'b1;
          next_s.m_state = ISB_M_IDLE;
        end
      end
      ISB_M_P1: begin
        if (rate_done) begin
          next_s.m_scl_low = 1'b0;
          next_s.m_state = ISB_M_P2;
          next_s.rate_generator = s.rate_reload;
        end
      end
      ISB_M_P2: begin
        if (!s.scl_f) begin
          next_s.rate_generator = s.rate_reload;
        end else if (rate_done) begin
          next_s.m_sda_low = 1'b0;
          next_s.m_state = ISB_M_P3;
          next_s.rate_generator = s.rate_reload;
        end
      end
      ISB_M_P3: begin
        if (rate_done) begin
          next_s.stop_request = 1'b0;
          next_s.m_irq = 1'b1;
          next_s.m_state = ISB_M_IDLE;
        end
      end
      ISB_M_BLO: begin
        // Low half of the bit: data settles while the clock is held low.
        next_s.m_sda_low = ~s.m_shift[8];
        if (rate_done) begin
          next_s.m_scl_low = 1'b0;
          next_s.m_state = ISB_M_BHI;
          next_s.rate_generator = s.rate_reload;
        end
      end
      ISB_M_BHI: begin
        if (!s.scl_f) begin
          next_s.rate_generator = s.rate_reload;
        end else if (rate_done) begin
          next_s.m_in = {s.m_in[6:0], s.sda_f};
          if (!s.m_rx && s.tx_go && s.m_left > 4'h1 && s.m_shift[8] && !s.sda_f) begin
            // Someone else pulled data low while we released it: lose the bus.
            next_s.bus_collision = 1'b1;
            next_s.tx_go = 1'b0;
            next_s.tx_holding_full = 1'b0;
            next_s.m_scl_low = 1'b0;
            next_s.m_sda_low = 1'b0;
            next_s.m_irq = 1'b1;
            next_s.m_state = ISB_M_IDLE;
          end else begin
            next_s.m_scl_low = 1'b1;
            next_s.m_shift = {s.m_shift[7:0], 1'b1};
            next_s.m_left = s.m_left - 4'h1;
            if (s.tx_go && s.m_left == 4'h2) begin
              next_s.tx_holding_full = 1'b0;
            end
            if (s.m_left == 4'h1) begin
              if (s.tx_go) begin
                next_s.ack_status = s.sda_f;
                next_s.tx_go = 1'b0;
              end else if (s.m_rx) begin
                next_s.rx_holding_reg = {s.m_in[6:0], s.sda_f};
                next_s.rx_holding_full = 1'b1;
                next_s.recv_request = 1'b0;
              end else begin
                next_s.ack_request = 1'b0;
              end
              next_s.m_irq = 1'b1;
              next_s.m_state = ISB_M_IDLE;
            end else begin
              next_s.m_state = ISB_M_BLO;
              next_s.rate_generator = s.rate_reload;
            end
          end
        end
      end
      default: begin
        next_s.m_state = ISB_M_IDLE;
      end
    endcase

    // Slave receiver and transmitter, watching every bus transfer.
    case (s.s_phase)
      ISB_SL_BYTE: begin
        if (scl_rise) begin
          next_s.s_shift = {s.s_shift[6:0], s.sda_f};
          next_s.s_cnt = s.s_cnt + 4'h1;
        end else if (scl_fall && s.s_cnt < 4'h8 && s.s_kind == ISB_K_TX) begin
          next_s.s_tx = {s.s_tx[6:0], 1'b1};
        end else if (scl_fall && s.s_cnt == 4'h8) begin
          next_s.s_phase = ISB_SL_IDLE;
          case (s.s_kind)
            ISB_K_ADDR1: begin
              if (!s.ten_bit && (match7 || match_gc)) begin
                next_s.slave_read = byte_in[0];
                next_s.s_kind = byte_in[0] ? ISB_K_TX : ISB_K_RX;
                next_s.s_phase = ISB_SL_ACKO;
                next_s.s_irq = 1'b1;
              end else if (s.ten_bit && match10_hi && !byte_in[0]) begin
                next_s.slave_read = 1'b0;
                next_s.s_kind = ISB_K_ADDR2;
                next_s.s_phase = ISB_SL_ACKO;
              end else if (s.ten_bit && match10_hi && s.ten_matched) begin
                next_s.slave_read = 1'b1;
                next_s.s_kind = ISB_K_TX;
                next_s.s_phase = ISB_SL_ACKO;
                next_s.s_irq = 1'b1;
              end
            end
            ISB_K_ADDR2: begin
              if (match10_lo) begin
                next_s.ten_matched = 1'b1;
                next_s.s_kind = ISB_K_RX;
                next_s.s_phase = ISB_SL_ACKO;
                next_s.s_irq = 1'b1;
              end
            end
            ISB_K_RX: begin
              next_s.rx_holding_reg = byte_in;
              next_s.rx_holding_full = 1'b1;
              next_s.s_phase = ISB_SL_ACKO;
              next_s.s_irq = 1'b1;
            end
            default: begin
              next_s.tx_holding_full = 1'b0;
              next_s.s_phase = ISB_SL_ACKI;
            end
          endcase
        end
      end
      ISB_SL_ACKO: begin
        if (scl_fall) begin
          next_s.s_phase = ISB_SL_BYTE;
          next_s.s_cnt = 4'h0;
          next_s.s_tx = s.tx_holding_reg;
        end
      end
      ISB_SL_ACKI: begin
        if (scl_rise) begin
          next_s.s_irq = 1'b1;
          if (s.sda_f) begin
            next_s.s_phase = ISB_SL_IDLE;
          end
        end else if (scl_fall) begin
          next_s.s_phase = ISB_SL_BYTE;
          next_s.s_cnt = 4'h0;
          next_s.s_tx = s.tx_holding_reg;
        end
      end
      default: begin
        next_s.s_phase = ISB_SL_IDLE;
      end
    endcase

    // Start and stop detection override whatever the slave was doing.
    if (start_det) begin
      next_s.start_seen = 1'b1;
      next_s.stop_seen = 1'b0;
      next_s.s_phase = ISB_SL_BYTE;
      next_s.s_kind = ISB_K_ADDR1;
      next_s.s_cnt = 4'h0;
    end else if (stop_det) begin
      next_s.start_seen = 1'b0;
      next_s.stop_seen = 1'b1;
      next_s.s_phase = ISB_SL_IDLE;
      next_s.ten_matched = 1'b0;
    end

    // A disabled controller parks both engines and lets go of the lines.
    if (!s.module_on) begin
      next_s.m_state = ISB_M_IDLE;
      next_s.s_phase = ISB_SL_IDLE;
      next_s.m_scl_low = 1'b0;
      next_s.m_sda_low = 1'b0;
      next_s.ten_matched = 1'b0;
    end

    // Pin ownership and registered pull-low requests.
    next_s.owned = next_s.module_on & ~PIN_HELD_ELSEWHERE;
    next_s.scl_low = next_s.owned & next_s.m_scl_low;
    next_s.sda_low = next_s.owned & (next_s.m_sda_low | (next_s.s_phase == ISB_SL_ACKO)
      | (next_s.s_phase == ISB_SL_BYTE && next_s.s_kind == ISB_K_TX
      && next_s.s_cnt < 4'h8 && !next_s.s_tx[7]));
  end

  // State register; everything clears on reset, leaving the lines released.
  always_ff @(posedge REF_CLK) begin
    if (RST) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  // Port drive from registered state; ready and line data are tied constant.
  assign PRDATA = s.prdata;
  assign PREADY = 1'b1;
  assign PSLVERR = s.pslverr;
  assign SCL_OUT = 1'b0;
  assign SDA_OUT = 1'b0;
  assign SCL_OE = s.scl_low;
  assign SDA_OE = s.sda_low;
  assign PIN_TAKEOVER = s.owned;
  assign MASTER_EVENT_IRQ = s.m_irq;
  assign SLAVE_EVENT_IRQ = s.s_irq;

endmodule // isb_i2c
`default_nettype wire

// ### sim/isb_chk.sv
// Port-level assertions for the two-wire bus controller.
`timescale 1ns/10ps
`default_nettype none
module isb_chk
  import isb_pkg::*;
#(
  parameter int ADDR_W = 8
) (
  // Clock, reset and APB.
  input wire logic REF_CLK,
  input wire logic RST,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [ADDR_W-1:0] PADDR,
  input wire logic [31:0] PWDATA,
  input wire logic PREADY,
  input wire logic PSLVERR,
  // Lines and pins.
  input wire logic SCL_OUT,
  input wire logic SCL_OE,
  input wire logic SDA_OUT,
  input wire logic SDA_OE,
  input wire logic PIN_HELD_ELSEWHERE,
  input wire logic PIN_TAKEOVER,
  // Event pulses.
  input wire logic MASTER_EVENT_IRQ,
  input wire logic SLAVE_EVENT_IRQ
);
  logic on, req, wr;
  logic [8:0] rate;
  logic [9:0] low;
  default clocking @(posedge REF_CLK); endclocking
  default disable iff (RST);
  // A write completes at the edge that sees the access phase with ready.
  assign wr = PSEL && PENABLE && PWRITE && PREADY;
  // Mirrors enable, a start, restart, stop or transmit request, the reload and the clock-low length.
  always_ff @(posedge REF_CLK) begin
    if (RST) begin
      on <= 1'b0;
      req <= 1'b0;
      rate <= 9'h000;
      low <= 10'h000;
    end else begin
      if (wr && PADDR == ISB_OFF_CTRL) on <= PWDATA[ISB_C_ON];
      if (wr && PADDR == ISB_OFF_RATE) rate <= PWDATA[8:0];
      if (wr && (PADDR == ISB_OFF_TXH || (PADDR == ISB_OFF_CTRL && PWDATA[2:0] != 3'h0)))
        req <= 1'b1;
      low <= SCL_OE ? low + {9'h000, ~&low} : 10'h000;
    end
  end
  takeover_a: assert property (PIN_TAKEOVER == (on && !$past(PIN_HELD_ELSEWHERE)))
    else $error("Pin takeover does not follow enable and claim");
  held_pins_a: assert property ($past(PIN_HELD_ELSEWHERE) && PIN_HELD_ELSEWHERE |-> !SCL_OE && !SDA_OE)
    else $error("Lines pulled while pins are claimed elsewhere");
  off_release_a: assert property (!$past(on) |-> !SCL_OE && !SDA_OE)
    else $error("Lines pulled while module is off");
  master_idle_a: assert property (!req |-> !SCL_OE)
    else $error("Clock pulled before any master request");
  open_drain_a: assert property (SCL_OUT == 1'b0 && SDA_OUT == 1'b0)
    else $error("Line driven high");
  master_pulse_a: assert property (MASTER_EVENT_IRQ |=> !MASTER_EVENT_IRQ)
    else $error("Master event longer than one cycle");
  slave_pulse_a: assert property (SLAVE_EVENT_IRQ |=> !SLAVE_EVENT_IRQ)
    else $error("Slave event longer than one cycle");
  clock_low_a: assert property ($fell(SCL_OE) |-> low >= {2'b00, rate[8:1]})
    else $error("Clock low shorter than one rate interval");
  unmapped_a: assert property (PSEL && PENABLE && PADDR > 8'h18 |-> PSLVERR)
    else $error("Unmapped access without error");
endmodule // isb_chk
`default_nettype wire

// ### sim/isb_peer.sv
// Bus-side target: pull-ups on both lines and an acknowledging device.
`timescale 1ns/10ps
`default_nettype none
module isb_peer (
  // Controller pulls and acknowledge command.
  input wire logic scl_oe,
  input wire logic sda_oe,
  input wire logic ack_en,
  // Resolved lines.
  output logic scl,
  output logic sda
);
  logic [3:0] bits = 4'h0;
  logic ack = 1'b0;
  // Released lines float high through the pull-ups.
  assign scl = !scl_oe;
  assign sda = !(sda_oe || ack);
  // Counts clock rises from each start and pulls data low for the ninth bit.
  always @(negedge sda) if (scl) bits = 4'h0;
  always @(posedge scl) bits = (bits == 4'h8) ? 4'h0 : bits + 4'h1;
  always @(negedge scl) ack = ack_en && bits == 4'h8;
endmodule // isb_peer
`default_nettype wire

// ### sim/isb_i2c_test.sv
// Self-checking bench of the two-wire bus controller.
`timescale 1ns/10ps
`default_nettype none
module isb_i2c_test;
  import isb_pkg::*;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic held = 1'b0;
  logic ack_en = 1'b1;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata, q;
  logic pready, pslverr, e, scl_oe, sda_oe, take, mirq, sirq;
  wire logic scl, sda;
  int miscompares = 0, n_compared = 0, cyc = 0, s_cnt = 0, t0, p;
  always #12.5 clk = ~clk;
  isb_i2c isb_i2c_i (.REF_CLK(clk), .RST(rst), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
    .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
    .SCL_IN(scl), .SCL_OUT(), .SCL_OE(scl_oe), .SDA_IN(sda), .SDA_OUT(), .SDA_OE(sda_oe),
    .PIN_HELD_ELSEWHERE(held), .PIN_TAKEOVER(take), .MASTER_EVENT_IRQ(mirq),
    .SLAVE_EVENT_IRQ(sirq));
  isb_peer isb_peer_i (.scl_oe(scl_oe), .sda_oe(sda_oe), .ack_en(ack_en), .scl(scl), .sda(sda));
  // One APB transfer, held until the edge that samples ready high.
  task automatic apb(input logic [7:0] a, input logic [31:0] d = 32'h0, input logic w = 1'b0);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // Compares and counts.
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      miscompares++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  // Waits a bounded time for the master completion pulse.
  task automatic wait_m();
    int n;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (mirq !== 1'b1 && n < 3000);
    chk({31'h0, mirq}, 32'h1);
  endtask
  // Prints the counts and the verdict, then ends the run.
  task automatic report_and_stop();
    $display("Compared %0d, mismatched %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  // Reset values, mask width and an unmapped place.
  task automatic t_regs();
    apb(ISB_OFF_STAT);
    chk(q, 32'h0);
    apb(ISB_OFF_MASK);
    chk(q, 32'h0);
    apb(ISB_OFF_MASK, 32'hFFFFFFFF, 1'b1);
    apb(ISB_OFF_MASK);
    chk(q, 32'h3FF);
    apb(8'h1C);
    chk({q[31:1], e}, 32'h1);
    $display("t_regs done");
  endtask
  // Enable, pin takeover, claim by another function.
  task automatic t_enable();
    apb(ISB_OFF_MASK, 32'h2, 1'b1);
    apb(ISB_OFF_OWN, 32'h50, 1'b1);
    apb(ISB_OFF_RATE, 32'h14, 1'b1);
    apb(ISB_OFF_CTRL, 32'h8000, 1'b1);
    repeat (3) @(posedge clk);
    chk({29'h0, take, scl_oe, sda_oe}, 32'h4);
    held <= 1'b1;
    repeat (3) @(posedge clk);
    chk({31'h0, take}, 32'h0);
    held <= 1'b0;
    repeat (2) @(posedge clk);
    $display("t_enable done");
  endtask
  // Start with a transmit load refused while it is pending.
  task automatic t_start();
    apb(ISB_OFF_CTRL, 32'h8001, 1'b1);
    apb(ISB_OFF_TXH, 32'h11, 1'b1);
    wait_m();
    apb(ISB_OFF_CTRL);
    chk(q, 32'h8000);
    apb(ISB_OFF_STAT);
    chk(q, 32'h88);
    apb(ISB_OFF_STAT, 32'h0, 1'b1);
    $display("t_start done");
  endtask
  // Own address with a masked bit, bit period, then a data byte to own slave.
  task automatic t_tx_rx();
    apb(ISB_OFF_TXH, 32'hA4, 1'b1);
    apb(ISB_OFF_STAT);
    chk({31'h0, q[0]}, 32'h1);
    @(posedge scl);
    t0 = cyc;
    @(posedge scl);
    p = cyc - t0;
    chk({31'h0, p >= 20 && p <= 30}, 32'h1);
    wait_m();
    apb(ISB_OFF_STAT);
    chk(q & 32'h8005, 32'h0);
    chk(s_cnt, 32'h1);
    apb(ISB_OFF_TXH, 32'h3C, 1'b1);
    wait_m();
    apb(ISB_OFF_STAT);
    chk({31'h0, q[1]}, 32'h1);
    chk(s_cnt, 32'h2);
    apb(ISB_OFF_RXH);
    chk(q, 32'h3C);
    apb(ISB_OFF_STAT);
    chk({31'h0, q[1]}, 32'h0);
    $display("t_tx_rx done");
  endtask
  // Restart, unmatched address left unacknowledged, stop, then a read address.
  task automatic t_miss_read();
    apb(ISB_OFF_CTRL, 32'h8002, 1'b1);
    wait_m();
    ack_en <= 1'b0;
    apb(ISB_OFF_TXH, 32'hA8, 1'b1);
    wait_m();
    apb(ISB_OFF_STAT);
    chk({31'h0, q[15]}, 32'h1);
    chk(s_cnt, 32'h2);
    ack_en <= 1'b1;
    apb(ISB_OFF_CTRL, 32'h8004, 1'b1);
    wait_m();
    apb(ISB_OFF_STAT);
    chk(q & 32'h18, 32'h10);
    apb(ISB_OFF_CTRL, 32'h8001, 1'b1);
    wait_m();
    apb(ISB_OFF_TXH, 32'hA5, 1'b1);
    wait_m();
    apb(ISB_OFF_STAT);
    chk(q & 32'h800C, 32'hC);
    chk(s_cnt, 32'h3);
    $display("t_miss_read done");
  endtask
  // Cycle count with a ceiling far above the planned run; slave events counted.
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (sirq === 1'b1) s_cnt <= s_cnt + 1;
    if (cyc == 20000) begin
      miscompares = miscompares + 1;
      report_and_stop();
    end
  end
  // Reset for two cycles, then the scenarios in order.
  initial begin
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    t_regs();
    t_enable();
    t_start();
    t_tx_rx();
    t_miss_read();
    report_and_stop();
  end
endmodule // isb_i2c_test
bind isb_i2c isb_chk #(.ADDR_W(ADDR_W)) isb_chk_i (.REF_CLK(REF_CLK), .RST(RST), .PSEL(PSEL),
  .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PREADY(PREADY),
  .PSLVERR(PSLVERR), .SCL_OUT(SCL_OUT), .SCL_OE(SCL_OE), .SDA_OUT(SDA_OUT), .SDA_OE(SDA_OE),
  .PIN_HELD_ELSEWHERE(PIN_HELD_ELSEWHERE), .PIN_TAKEOVER(PIN_TAKEOVER),
  .MASTER_EVENT_IRQ(MASTER_EVENT_IRQ), .SLAVE_EVENT_IRQ(SLAVE_EVENT_IRQ));
`default_nettype wire
